// ==== verification/fault_host_model.sv ====
// host model: issues one serial command at a time to the fault block.
// assumes the caller waits for each call to return before the next one.
`default_nettype none

module fault_host_model (
  input  wire logic                 clk_i,
  output var fault_pkg::command_s   cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmd_o = '0;
  // idle data is inverted so a stale word never passes for a fresh one
  task automatic send(input fault_pkg::command_e code, input logic [31:0] data);
    @(posedge clk_i);
    cmd_o <= {1'b1, code, data};
    @(posedge clk_i);
    cmd_o <= {1'b0, fault_pkg::CMD_NONE, ~data};
  endtask
endmodule

`default_nettype wire

// ==== verification/fault_status_register_props.sv ====
// checker for the fault status register: flag relations and response timing.
// assumes one clock domain; attached to every instance by the bind below.
`default_nettype none

module fault_status_register_props (
  input wire logic                     clk_i,
  input wire logic                     nrst_i,
  input wire fault_pkg::command_s      cmd_i,
  input wire fault_pkg::fault_events_s events_i,
  input wire logic                     self_test_done_i,
  input wire logic                     enable_pin_i,
  input wire logic                     image_download_req_i,
  input wire logic                     resp_valid_o,
  input wire logic [63:0]              resp_data_o,
  input wire logic [31:0]              fault_flags_o,
  input wire logic                     output_active_o,
  input wire logic                     image_download_ok_o
);
  // ==========================================================================
  // helpers
  logic [1:0] cyc;
  wire logic [31:0] ev_set = {16'h0000, events_i[0], events_i[1], 2'h0, events_i[2], 1'b0,
    events_i[4], events_i[5], 3'h0, events_i[8], events_i[9], events_i[10], events_i[11],
    events_i[12]};
  wire logic is_clr = cmd_i.valid && cmd_i.code == fault_pkg::CMD_CLEAR_FAULT;
  // self-test capture may still move bits 5 and 7 in the first edges after reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) cyc <= 2'h0;
    else if (cyc != 2'h3) cyc <= cyc + 2'h1;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ==========================================================================
  // properties
  property p_off;
    fault_flags_o != 32'h0000_0000 |=> !output_active_o;
  endproperty
  a_off: assert property (p_off) else $error("output on with fault");
  property p_selftest;
    cyc[1] |-> $stable(fault_flags_o[7]) && $stable(fault_flags_o[5]);
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test bit moved");
  property p_sticky;
    ev_set != 32'h0000_0000 |=> (fault_flags_o & $past(ev_set)) == $past(ev_set);
  endproperty
  a_sticky: assert property (p_sticky) else $error("event not latched");
  property p_image;
    image_download_ok_o == (image_download_req_i && !fault_flags_o[3]);
  endproperty
  a_image: assert property (p_image) else $error("image download gate wrong");
  property p_cool;
    cyc != 2'h0 |-> fault_flags_o[10] == $past(events_i.cooldown_active);
  endproperty
  a_cool: assert property (p_cool) else $error("cooldown bit wrong");
  property p_clear;
    is_clr && events_i == '0 && !enable_pin_i
      |=> (fault_flags_o & ~fault_pkg::SELF_TEST_MASK) == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left bits");
  property p_comb;
    cmd_i.valid && cmd_i.code == fault_pkg::CMD_READ_COMBINED
      |=> resp_valid_o && resp_data_o[63:32] == $past(fault_flags_o);
  endproperty
  a_comb: assert property (p_comb) else $error("combined read wrong");
  property p_read;
    cmd_i.valid && cmd_i.code == fault_pkg::CMD_READ_FAULT
      |=> resp_valid_o && resp_data_o == {32'h0000_0000, $past(fault_flags_o)};
  endproperty
  a_read: assert property (p_read) else $error("fault read wrong");
  property p_noresp;
    !cmd_i.valid |=> !resp_valid_o;
  endproperty
  a_noresp: assert property (p_noresp) else $error("response without command");
  property p_resv;
    (fault_flags_o & 32'hFFFF_0040) == 32'h0000_0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
endmodule

bind fault_status_register fault_status_register_props chk_u (.clk_i, .nrst_i, .cmd_i,
  .events_i, .self_test_done_i, .enable_pin_i, .image_download_req_i, .resp_valid_o,
  .resp_data_o, .fault_flags_o, .output_active_o, .image_download_ok_o);

`default_nettype wire

// ==== verification/test_fault_status_register.sv ====
// testbench for the fault status register: host model commands, event stimulus, monitor.
// assumes the host model and the checker bind are compiled alongside.
`default_nettype none

module test_fault_status_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk_i = 1'b0;
  logic                     nrst_i = 1'b0;
  fault_pkg::command_s      cmd;
  fault_pkg::fault_events_s ev = '0;
  logic                     st_done = 1'b0;
  logic                     pin = 1'b0;
  logic                     img_req = 1'b0;
  logic                     resp_valid;
  logic [63:0]              resp_data;
  logic [31:0]              flags;
  logic                     out_on;
  logic                     img_ok;
  logic [127:0]             expq[$];
  int                       err_count = 0;
  int                       comparisons = 0;
  int                       pos[13] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 10, 11, 14, 15};
  localparam logic [63:0]   NO_OK = 64'hFFFF_FFFF_FFFF_FFF7;

  always #5 clk_i = ~clk_i;
  fault_host_model host_u (.clk_i(clk_i), .cmd_o(cmd));
  fault_status_register dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd), .events_i(ev),
    .self_test_done_i(st_done), .enable_pin_i(pin), .image_download_req_i(img_req),
    .resp_valid_o(resp_valid), .resp_data_o(resp_data), .fault_flags_o(flags),
    .output_active_o(out_on), .image_download_ok_o(img_ok));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check({32'h0000_0000, got}, {32'h0000_0000, exp});
  endtask
  // mask drops status bits whose moment of update is left open
  task automatic cmd_exp(input fault_pkg::command_e c, input logic [31:0] d,
                         input logic [63:0] e, input logic [63:0] m = '1);
    expq.push_back({m, e & m});
    host_u.send(c, d);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic do_reset(input fault_pkg::fault_events_s e, input logic p, input logic d);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    ev <= e;
    pin <= p;
    st_done <= d;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    ev <= '0;
    pin <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pin_set(input logic p);
    pin <= p;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    logic [127:0] e;
    if (resp_valid === 1'b1) begin
      if (expq.size() == 0) check(resp_data, ~resp_data);
      else begin
        e = expq.pop_front();
        check(resp_data & e[127:64], e[63:0]);
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    summarize();
  end

  initial begin
    fault_pkg::fault_events_s st;
    st = '0;
    st.config_bad = 1'b1;
    st.calibration_bad = 1'b1;
    void'($urandom(32'hd788_cd5e));
    do_reset(st, 1'b1, 1'b1);
    chk32(flags, 32'h0000_10A0);
    cmd_exp(fault_pkg::CMD_CLEAR_FAULT, 32'h0000_0000, 64'h0);
    chk32(flags, 32'h0000_00A0);
    cmd_exp(fault_pkg::CMD_WRITE_STATUS, 32'h0000_0041, 64'h41, NO_OK);
    pin_set(1'b1);
    chk32(flags, 32'h0000_00A0);
    chk32({31'h0, out_on}, 32'h0);
    // corrupt results without a finished self test must not latch
    do_reset(st, 1'b0, 1'b0);
    chk32(flags, 32'h0000_0000);
    cmd_exp(fault_pkg::CMD_WRITE_STATUS, 32'h0000_0005, 64'hD);
    cmd_exp(fault_pkg::CMD_READ_COMBINED, 32'h0000_0000, 64'hD);
    chk32({31'h0, out_on}, 32'h1);
    foreach (pos[i]) begin
      if (i == 5 || i == 6 || i == 9) continue;
      ev[12 - i] <= 1'b1;
      img_req <= 1'b1;
      repeat (1 + $urandom % 4) @(posedge clk_i);
      ev <= '0;
      cmd_exp(fault_pkg::CMD_READ_FAULT, $urandom, 64'h1 << pos[i]);
      chk32({31'h0, img_ok}, (i == 3) ? 32'h0 : 32'h1);
      chk32({31'h0, out_on}, 32'h0);
      cmd_exp(fault_pkg::CMD_CLEAR_FAULT, 32'h0000_0000, 64'h0);
      chk32(flags, 32'h0000_0000);
    end
    cmd_exp(fault_pkg::CMD_WRITE_STATUS, 32'h0000_0001, 64'h9);
    ev.cooldown_active <= 1'b1;
    cmd_exp(fault_pkg::CMD_WRITE_STATUS, 32'h0000_0005, 64'h1, NO_OK);
    chk32(flags, 32'h0000_0400);
    ev <= '0;
    repeat (2) @(posedge clk_i);
    chk32(flags, 32'h0000_0000);
    cmd_exp(fault_pkg::CMD_READ_STATUS, 32'h0000_0000, 64'h9);
    pin <= 1'b1;
    cmd_exp(fault_pkg::CMD_WRITE_STATUS, 32'h0000_0041, 64'h45, NO_OK);
    chk32(flags, 32'h0000_2000);
    pin_set(1'b0);
    pin_set(1'b1);
    chk32(flags, 32'h0000_0000);
    chk32({31'h0, out_on}, 32'h1);
    pin_set(1'b0);
    chk32({31'h0, out_on}, 32'h0);
    host_u.send(fault_pkg::command_e'(3'h6), 32'h0000_0000);
    host_u.send(fault_pkg::CMD_NONE, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    // every noted answer must have been seen by the monitor
    check({32'h0000_0000, expq.size()}, 64'h0000_0000_0000_0000);
    summarize();
  end
endmodule

`default_nettype wire

// ==== verilog/fault_pkg.sv ====
// package for the fault status register block: bit positions, masks, command codes.
// assumes a single 100 MHz clock domain; all users reference items as fault_pkg::name.
`default_nettype none

package fault_pkg;

  // ==========================================================================
  // fault register bit positions
  localparam int unsigned STAGE_OVERHEAT_BIT      = 0;
  localparam int unsigned LOAD_OR_OVERCURRENT_BIT = 1;
  localparam int unsigned SUPPLY_RANGE_BIT        = 2;
  localparam int unsigned ACCESSORY_IMAGE_BIT     = 3;
  localparam int unsigned DEFAULTS_CHECK_BIT      = 4;
  localparam int unsigned CONFIG_CHECK_BIT        = 5;
  localparam int unsigned CAL_CHECK_BIT           = 7;
  localparam int unsigned SETTINGS_LOAD_BIT       = 8;
  localparam int unsigned TEMP_EXCEEDED_BIT       = 9;
  localparam int unsigned COOLDOWN_BIT            = 10;
  localparam int unsigned TEMP_NEAR_LIMIT_BIT     = 11;
  localparam int unsigned PIN_HIGH_POWERUP_BIT    = 12;
  localparam int unsigned PIN_HIGH_SWITCH_BIT     = 13;
  localparam int unsigned REGULATOR_SAT_BIT       = 14;
  localparam int unsigned CURRENT_RANGE_BIT       = 15;

  // ==========================================================================
  // masks and reset values
  localparam logic [31:0] IMPLEMENTED_MASK = 32'h0000_FFBF;
  localparam logic [31:0] SELF_TEST_MASK   = 32'h0000_00A0;
  localparam logic [31:0] FAULT_RESET      = 32'h0000_0000;
  localparam logic [31:0] LASER_STAT_RESET = 32'h0000_0001;

  // laser status register fields
  localparam int unsigned LS_OUTPUT_ON_BIT  = 0;
  localparam int unsigned LS_ENABLE_BIT     = 2;
  localparam int unsigned LS_NO_FAULT_BIT   = 3;
  localparam int unsigned LS_EXT_SELECT_BIT = 6;
  localparam logic [31:0] LS_WRITE_MASK     = 32'h0000_00D7;

  // ==========================================================================
  // command codes carried by the command port (values arbitrary)
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ_FAULT,
    CMD_READ_COMBINED,
    CMD_READ_STATUS,
    CMD_WRITE_STATUS,
    CMD_CLEAR_FAULT
  } command_e;

  typedef struct packed {
    logic        valid;
    command_e    code;
    logic [31:0] data;
  } command_s;

  // raw fault conditions from the monitors and the self test
  typedef struct packed {
    logic stage_overheat;
    logic load_or_overcurrent;
    logic supply_out_of_range;
    logic accessory_image_bad;
    logic defaults_bad;
    logic config_bad;
    logic calibration_bad;
    logic settings_load_failed;
    logic temp_exceeded;
    logic cooldown_active;
    logic temp_near_limit;
    logic regulator_saturated;
    logic current_out_of_range;
  } fault_events_s;

endpackage

`default_nettype wire

// ==== verilog/fault_status_register.sv ====
// fault status register with the companion laser status control bits.
// assumes commands arrive as one-cycle valid pulses; monitors give level conditions.
// Operation
// - any fault bit set keeps the current output off
// - configuration and calibration corrupt bits come only from the power-on self test
// - self-test bits survive enable pin and clear command; only power cycle removes
// - bit 0 set on output stage overtemperature shutdown
// - bit 1 set on load failure or overcurrent shutdown
// - bit 2 set while supply voltage is outside safe range
// - bit 3 set on bad accessory image; image download then refused
// - bit 4 set when stored default settings fail their check
// - bit 5 set when stored configuration fails its check
// - bit 7 set when stored calibration fails its check
// - bit 8 set when last load of saved defaults failed
// - bit 9 set once temperature exceeded maximum operating temperature
// - bit 10 held during cooldown; re-enable rejected until it clears
// - bit 11 warns that temperature nears the shutdown threshold
// - bit 12 set if enable pin high at power-on, valid with external select
// - bit 13 set if enable pin high when external select is set
// - bit 14 set when regulator saturates without reaching setpoint
// - bit 15 set when output current leaves its safe range
// - clear command resets only the clearable fault bits
// - combined read: status in low 32 bits, faults in upper 32 bits
// - external select picks enable pin, else software enable bit
`default_nettype none

module fault_status_register (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire fault_pkg::command_s      cmd_i,
  input  wire fault_pkg::fault_events_s events_i,
  input  wire logic                     self_test_done_i,
  input  wire logic                     enable_pin_i,
  input  wire logic                     image_download_req_i,
  output logic                          resp_valid_o,
  output logic [63:0]                   resp_data_o,
  output logic [31:0]                   fault_flags_o,
  output logic                          output_active_o,
  output logic                          image_download_ok_o
);

  // ==========================================================================
  // command decode
  wire logic cmd_clear;
  wire logic cmd_write;
  wire logic cmd_rd_fault;
  wire logic cmd_rd_comb;
  wire logic cmd_rd_stat;
  assign cmd_clear    = cmd_i.valid && cmd_i.code == fault_pkg::CMD_CLEAR_FAULT;
  assign cmd_write    = cmd_i.valid && cmd_i.code == fault_pkg::CMD_WRITE_STATUS;
  assign cmd_rd_fault = cmd_i.valid && cmd_i.code == fault_pkg::CMD_READ_FAULT;
  assign cmd_rd_comb  = cmd_i.valid && cmd_i.code == fault_pkg::CMD_READ_COMBINED;
  assign cmd_rd_stat  = cmd_i.valid && cmd_i.code == fault_pkg::CMD_READ_STATUS;

  // undecoded codes get no answer, so stale data is never acknowledged
  wire logic cmd_known;
  assign cmd_known = cmd_clear || cmd_write || cmd_rd_fault || cmd_rd_comb || cmd_rd_stat;

  // ==========================================================================
  // laser status register (software side of enabling)
  logic [31:0] laser_status_register;
  logic [31:0] next_status;
  logic        powerup_sampled;

  wire logic ext_select;
  wire logic sw_enable;
  wire logic select_rising;
  assign ext_select    = laser_status_register[fault_pkg::LS_EXT_SELECT_BIT];
  assign sw_enable     = laser_status_register[fault_pkg::LS_ENABLE_BIT];
  assign select_rising = cmd_write && cmd_i.data[fault_pkg::LS_EXT_SELECT_BIT] && !ext_select;

  // ==========================================================================
  // enable pin
  wire logic pin_level;
  wire logic pin_rise;

  pin_edge_detect u_pin (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .level_i (enable_pin_i),
    .level_o (pin_level),
    .rise_o  (pin_rise)
  );

  // ==========================================================================
  // fault flag set terms
  logic [15:0] set_vec;
  logic [15:0] flags;
  logic        any_fault;
  logic        cooldown;

  // self-test results are sampled only while the self test reports done
  wire logic self_test_cfg;
  wire logic self_test_cal;
  assign self_test_cfg = self_test_done_i && !powerup_sampled && events_i.config_bad;
  assign self_test_cal = self_test_done_i && !powerup_sampled && events_i.calibration_bad;

  always_comb begin
    set_vec                                       = 16'h0000;
    set_vec[fault_pkg::STAGE_OVERHEAT_BIT]        = events_i.stage_overheat;
    set_vec[fault_pkg::LOAD_OR_OVERCURRENT_BIT]   = events_i.load_or_overcurrent;
    set_vec[fault_pkg::SUPPLY_RANGE_BIT]          = events_i.supply_out_of_range;
    set_vec[fault_pkg::ACCESSORY_IMAGE_BIT]       = events_i.accessory_image_bad;
    set_vec[fault_pkg::DEFAULTS_CHECK_BIT]        = events_i.defaults_bad;
    set_vec[fault_pkg::CONFIG_CHECK_BIT]          = self_test_cfg;
    set_vec[fault_pkg::CAL_CHECK_BIT]             = self_test_cal;
    set_vec[fault_pkg::SETTINGS_LOAD_BIT]         = events_i.settings_load_failed;
    set_vec[fault_pkg::TEMP_EXCEEDED_BIT]         = events_i.temp_exceeded;
    set_vec[fault_pkg::TEMP_NEAR_LIMIT_BIT]       = events_i.temp_near_limit;
    // power-on pin check happens once, at the first cycle after reset
    set_vec[fault_pkg::PIN_HIGH_POWERUP_BIT]      = !powerup_sampled && pin_level;
    set_vec[fault_pkg::PIN_HIGH_SWITCH_BIT]       = select_rising && pin_level;
    set_vec[fault_pkg::REGULATOR_SAT_BIT]         = events_i.regulator_saturated;
    set_vec[fault_pkg::CURRENT_RANGE_BIT]         = events_i.current_out_of_range;
  end

  // clearable bits drop on the clear command or a fresh rising edge of the pin while external select is set
  wire logic clear_pulse;
  assign clear_pulse = cmd_clear || (ext_select && pin_rise);

  sticky_bit u_stage_overheat (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::STAGE_OVERHEAT_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::STAGE_OVERHEAT_BIT])
  );

  sticky_bit u_overcurrent (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::LOAD_OR_OVERCURRENT_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::LOAD_OR_OVERCURRENT_BIT])
  );

  sticky_bit u_supply_range (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::SUPPLY_RANGE_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::SUPPLY_RANGE_BIT])
  );

  sticky_bit u_accessory_image (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::ACCESSORY_IMAGE_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::ACCESSORY_IMAGE_BIT])
  );

  sticky_bit u_defaults_check (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::DEFAULTS_CHECK_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::DEFAULTS_CHECK_BIT])
  );

  // self-test bits ignore every clear; only a power cycle removes them
  sticky_bit #(.CLEARABLE(1'b0)) u_config_check (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::CONFIG_CHECK_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::CONFIG_CHECK_BIT])
  );

  sticky_bit #(.CLEARABLE(1'b0)) u_cal_check (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::CAL_CHECK_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::CAL_CHECK_BIT])
  );

  sticky_bit u_settings_load (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::SETTINGS_LOAD_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::SETTINGS_LOAD_BIT])
  );

  sticky_bit u_temp_exceeded (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::TEMP_EXCEEDED_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::TEMP_EXCEEDED_BIT])
  );

  sticky_bit u_temp_near_limit (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::TEMP_NEAR_LIMIT_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::TEMP_NEAR_LIMIT_BIT])
  );

  sticky_bit u_pin_powerup (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::PIN_HIGH_POWERUP_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::PIN_HIGH_POWERUP_BIT])
  );

  sticky_bit u_pin_switch (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::PIN_HIGH_SWITCH_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::PIN_HIGH_SWITCH_BIT])
  );

  sticky_bit u_regulator_sat (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::REGULATOR_SAT_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::REGULATOR_SAT_BIT])
  );

  sticky_bit u_current_range (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (set_vec[fault_pkg::CURRENT_RANGE_BIT]),
    .clear_i (clear_pulse),
    .flag_o  (flags[fault_pkg::CURRENT_RANGE_BIT])
  );

  // reserved bit and the cooldown slot are not sticky flags
  assign flags[6]                       = 1'b0;
  assign flags[fault_pkg::COOLDOWN_BIT] = 1'b0;

  // cooldown tracks the thermal monitor directly and cannot be cleared by software
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cooldown <= 1'b0;
    end else begin
      cooldown <= events_i.cooldown_active;
    end
  end

  wire logic [31:0] fault_word;
  assign fault_word = ({16'h0000, flags} | ({31'h0000_0000, cooldown} << fault_pkg::COOLDOWN_BIT))
                      & fault_pkg::IMPLEMENTED_MASK;
  assign any_fault  = |fault_word;

  // ==========================================================================
  // status register update
  always_comb begin
    next_status = laser_status_register;
    if (cmd_write) begin
      next_status = (cmd_i.data & fault_pkg::LS_WRITE_MASK)
                    | (laser_status_register & ~fault_pkg::LS_WRITE_MASK);
      // software enable is read-only while the pin is selected
      if (ext_select) begin
        next_status[fault_pkg::LS_ENABLE_BIT] = laser_status_register[fault_pkg::LS_ENABLE_BIT];
      end
      // re-enable refused during cooldown
      if (cooldown && !laser_status_register[fault_pkg::LS_ENABLE_BIT]) begin
        next_status[fault_pkg::LS_ENABLE_BIT] = 1'b0;
      end
    end
    if (next_status[fault_pkg::LS_EXT_SELECT_BIT]) begin
      next_status[fault_pkg::LS_ENABLE_BIT] = pin_level && !cooldown;
    end
    next_status[fault_pkg::LS_NO_FAULT_BIT] = !any_fault;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      laser_status_register <= fault_pkg::LASER_STAT_RESET;
      powerup_sampled       <= 1'b0;
    end else begin
      laser_status_register <= next_status;
      powerup_sampled       <= 1'b1;
    end
  end

  // ==========================================================================
  // output gating
  wire logic enabled;
  assign enabled = ext_select ? pin_level : sw_enable;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_active_o <= 1'b0;
    end else begin
      output_active_o <= enabled && laser_status_register[fault_pkg::LS_OUTPUT_ON_BIT]
                         && !any_fault && !cooldown;
    end
  end

  assign image_download_ok_o = image_download_req_i && !flags[fault_pkg::ACCESSORY_IMAGE_BIT];
  assign fault_flags_o       = fault_word;

  // ==========================================================================
  // read responses, registered one cycle after the command
  wire logic [63:0] comb_word;
  assign comb_word = {fault_word, laser_status_register};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_valid_o <= 1'b0;
      resp_data_o  <= 64'h0000_0000_0000_0000;
    end else begin
      resp_valid_o <= cmd_known;
      if (cmd_rd_comb) begin
        resp_data_o <= comb_word;
      end else if (cmd_rd_fault) begin
        resp_data_o <= {32'h0000_0000, fault_word};
      end else if (cmd_rd_stat) begin
        resp_data_o <= {32'h0000_0000, laser_status_register};
      end else if (cmd_write) begin
        resp_data_o <= {32'h0000_0000, next_status};
      end else if (cmd_clear) begin
        resp_data_o <= 64'h0000_0000_0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// ==== verilog/pin_edge_detect.sv ====
// rising-edge detector for the external enable pin (pin taken as synchronous).
// assumes the pin input is already in the clk_i domain.
`default_nettype none

module pin_edge_detect (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic level_i,
  output logic      level_o,
  output logic      rise_o
);

  logic prev;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= level_i;
    end
  end

  assign level_o = level_i;
  assign rise_o  = level_i & ~prev;

endmodule

`default_nettype wire

// ==== verilog/sticky_bit.sv ====
// one sticky flag: set by hardware, optionally cleared by a clear pulse.
// assumes clk_i/nrst_i of the fault block; set wins over clear in the same cycle.
`default_nettype none

module sticky_bit #(
  parameter bit CLEARABLE = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  wire logic do_clear;
  assign do_clear = CLEARABLE & clear_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (do_clear) begin
      flag_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire
